// ===== rtl/umc_pkg.sv
/*
 Package for the serial mode control block: register offset, field positions,
 reset values and the structs that carry pin and mode signals.
 Assumes a 32-bit register port and a 250 MHz core clock.
*/
package umc_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0] UMC_OFS_MODE = 4'h0;
   localparam logic [3:0] UMC_OFS_STATUS = 4'h4;
   localparam logic [31:0] UMC_MODE_RESET = 32'h0000_0000;
   localparam logic [31:0] UMC_MODE_WMASK = 32'h0000_BBFF;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int UMC_BIT_ENABLE = 15;
   localparam int UMC_BIT_STOP_IDLE = 13;
   localparam int UMC_BIT_IR = 12;
   localparam int UMC_BIT_RTS_MODE = 11;
   localparam int UMC_BIT_PIN_LO = 8;
   localparam int UMC_BIT_WAKE = 7;
   localparam int UMC_BIT_LOOP = 6;

   // ****************************************
   // Pin usage encodings
   // ****************************************
   localparam logic [1:0] UMC_PINS_TXRX = 2'h0;
   localparam logic [1:0] UMC_PINS_RTS = 2'h1;
   localparam logic [1:0] UMC_PINS_CTS_RTS = 2'h2;
   localparam logic [1:0] UMC_PINS_BCLK = 2'h3;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic module_enable;
      logic stop_in_idle;
      logic infrared_codec_enable;
      logic request_to_send_mode;
      logic [1:0] pin_usage_select;
      logic wake_enable;
      logic loopback_select;
      logic [5:0] lower_bits;
   } umc_mode_type;

   typedef struct packed {
      logic tx_out;
      logic tx_oe;
      logic rts_out;
      logic rts_oe;
      logic bclk_out;
      logic cts_owned;
      logic rx_owned;
   } umc_pins_type;

   typedef struct packed {
      umc_mode_type mode;
      logic [1:0] rx_sync;
      logic [1:0] cts_sync;
      logic rx_prev;
      logic wake;
      logic [31:0] rdata;
      logic [2:0] ir_cnt;
   } umc_state_type;

endpackage

// ===== rtl/umc_mode_ctrl.sv
/*
 Mode control and pin steering for one serial port: holds the mode register,
 routes the transmit and receive streams through the infrared codec or past it,
 drives pins by pin usage, handles loopback, idle stop and wake on start bit.
 Assumes a serial core on the same clock, and port logic that takes back every
 pin whose ownership output is low.
*/
// Functional notes
// - Bits 31 to 16 of the mode register always read zero.
// - Enable set gives pins to the port, per pin usage and transmit enable.
// - Enable clear returns all pins to port logic; core held quiet.
// - Stop-in-idle set halts the port while the device idles.
// - Infrared enable routes transmit and receive through the codec.
// - Request-to-send mode one is simplex, zero is flow control.
// - Pin usage selects which of request, clear and baud clock pins are used.
// - Wake enable lets a start bit during sleep wake the device.
// - Loopback select puts the port into loopback mode.
// - Bits 14 and 10 are not implemented and read zero.
`timescale 1ns/1ps
module umc_mode_ctrl
   import umc_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic transmit_enable,
   input wire logic device_idle,
   input wire logic device_sleep,
   input wire logic core_tx_bit,
   input wire logic core_rts_request,
   input wire logic core_tx_busy,
   input wire logic baud_clock_in,
   output logic core_rx_bit,
   output logic core_cts_ok,
   output logic core_run,
   output logic serial_tx_pin,
   output logic serial_tx_oe,
   input wire logic serial_rx_pin,
   output logic request_to_send_n,
   output logic request_to_send_oe,
   input wire logic clear_to_send_n,
   output logic baud_clock_out,
   output logic baud_clock_oe,
   output logic rx_pin_owned,
   output logic cts_pin_owned,
   output logic wake_request,
   output logic [31:0] mode_view
);

   // ****************************************
   // State
   // ****************************************
   umc_state_type s_q;
   umc_state_type s_d;
   umc_pins_type pins;
   logic run;
   logic rx_line;
   logic tx_coded;
   logic [31:0] mode_word;

   function automatic logic [31:0] umc_pack(input umc_mode_type m);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[UMC_BIT_ENABLE] = m.module_enable;
      w[UMC_BIT_STOP_IDLE] = m.stop_in_idle;
      w[UMC_BIT_IR] = m.infrared_codec_enable;
      w[UMC_BIT_RTS_MODE] = m.request_to_send_mode;
      w[UMC_BIT_PIN_LO +: 2] = m.pin_usage_select;
      w[UMC_BIT_WAKE] = m.wake_enable;
      w[UMC_BIT_LOOP] = m.loopback_select;
      w[5:0] = m.lower_bits;
      return w;
   endfunction

   function automatic umc_mode_type umc_unpack(input logic [31:0] w);
      umc_mode_type m;
      m.module_enable = w[UMC_BIT_ENABLE];
      m.stop_in_idle = w[UMC_BIT_STOP_IDLE];
      m.infrared_codec_enable = w[UMC_BIT_IR];
      m.request_to_send_mode = w[UMC_BIT_RTS_MODE];
      m.pin_usage_select = w[UMC_BIT_PIN_LO +: 2];
      m.wake_enable = w[UMC_BIT_WAKE];
      m.loopback_select = w[UMC_BIT_LOOP];
      m.lower_bits = w[5:0];
      return m;
   endfunction

   assign mode_word = umc_pack(s_q.mode);

   // ****************************************
   // Run control
   // ****************************************
   // Disabled or idling with stop set: core frozen to save power
   assign run = s_q.mode.module_enable && !(s_q.mode.stop_in_idle && device_idle);

   // ****************************************
   // Infrared encoder: a zero bit becomes a short high pulse
   // ****************************************
   // Pulse is three core clocks; a real codec would time it from the baud tick
   assign tx_coded = s_q.mode.infrared_codec_enable ? (s_q.ir_cnt != 3'h0) : core_tx_bit;

   // Loopback takes the coded stream so the decoder is exercised too
   assign rx_line = s_q.mode.loopback_select ? tx_coded : s_q.rx_sync[1];

   // ****************************************
   // Pin steering
   // ****************************************
   always_comb
   begin
      pins = '0;
      pins.tx_out = 1'b1;
      pins.rts_out = 1'b1;
      if (s_q.mode.module_enable)
      begin
         pins.rx_owned = 1'b1;
         pins.tx_oe = transmit_enable && !s_q.mode.loopback_select;
         pins.tx_out = run ? tx_coded : 1'b1;
         case (s_q.mode.pin_usage_select)
            UMC_PINS_TXRX:
            begin
               pins.rts_oe = 1'b0;
            end
            UMC_PINS_RTS:
            begin
               pins.rts_oe = 1'b1;
            end
            UMC_PINS_CTS_RTS:
            begin
               pins.rts_oe = 1'b1;
               pins.cts_owned = 1'b1;
            end
            UMC_PINS_BCLK:
            begin
               pins.bclk_out = run && baud_clock_in;
            end
            default:
            begin
               pins.rts_oe = 1'b0;
            end
         endcase
         // Simplex: asserted while sending; flow control: receiver ready
         if (s_q.mode.request_to_send_mode)
            pins.rts_out = !(run && core_tx_busy);
         else
            pins.rts_out = !(run && core_rts_request);
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      s_d = s_q;
      s_d.rx_sync = {s_q.rx_sync[0], serial_rx_pin};
      s_d.cts_sync = {s_q.cts_sync[0], clear_to_send_n};
      s_d.rx_prev = rx_line;
      s_d.rdata = 32'h0000_0000;
      if (reg_read)
      begin
         case (reg_addr)
            UMC_OFS_MODE: s_d.rdata = mode_word;
            UMC_OFS_STATUS: s_d.rdata = {29'h0, s_q.wake, run, rx_line};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
      if (reg_write && reg_addr == UMC_OFS_MODE)
         s_d.mode = umc_unpack(reg_wdata & UMC_MODE_WMASK);
      // Status write of one clears wake; a new start bit wins
      if (reg_write && reg_addr == UMC_OFS_STATUS && reg_wdata[2])
         s_d.wake = 1'b0;
      if (s_q.mode.module_enable && s_q.mode.wake_enable && device_sleep
          && s_q.rx_prev && !rx_line)
         s_d.wake = 1'b1;
      if (!run || !s_q.mode.infrared_codec_enable)
         s_d.ir_cnt = 3'h0;
      else if (s_q.ir_cnt != 3'h0)
         s_d.ir_cnt = s_q.ir_cnt - 3'h1;
      else if (!core_tx_bit && s_q.rx_prev == rx_line)
         s_d.ir_cnt = 3'h3;
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         s_q <= '0;
         s_q.mode <= umc_unpack(UMC_MODE_RESET);
         s_q.rx_sync <= 2'h3;
         s_q.cts_sync <= 2'h3;
         s_q.rx_prev <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Decoder: a received high pulse is a zero bit
   assign core_rx_bit = !run ? 1'b1 : (s_q.mode.infrared_codec_enable ? !rx_line : rx_line);
   assign core_cts_ok = run && (!pins.cts_owned || !s_q.cts_sync[1]);
   assign core_run = run;
   assign serial_tx_pin = pins.tx_out;
   assign serial_tx_oe = pins.tx_oe;
   assign request_to_send_n = pins.rts_out;
   assign request_to_send_oe = pins.rts_oe;
   assign baud_clock_out = pins.bclk_out;
   assign baud_clock_oe = s_q.mode.module_enable && s_q.mode.pin_usage_select == UMC_PINS_BCLK;
   assign rx_pin_owned = pins.rx_owned && !s_q.mode.loopback_select;
   assign cts_pin_owned = pins.cts_owned;
   assign wake_request = s_q.wake;
   assign reg_rdata = s_q.rdata;
   assign mode_view = mode_word;

endmodule

// ===== verif/umc_mode_ctrl_assertions.sv
/*
 Checker for the serial mode control block, bound onto its ports.
 Assumes one clock domain and the async active-high reset.
*/
`timescale 1ns/1ps
module umc_chk
   import umc_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [31:0] reg_rdata,
   input wire logic transmit_enable,
   input wire logic device_idle,
   input wire logic device_sleep,
   input wire logic core_tx_bit,
   input wire logic core_tx_busy,
   input wire logic core_rx_bit,
   input wire logic core_run,
   input wire logic serial_tx_oe,
   input wire logic request_to_send_n,
   input wire logic request_to_send_oe,
   input wire logic baud_clock_oe,
   input wire logic rx_pin_owned,
   input wire logic wake_request,
   input wire logic [31:0] mode_view
);
   // ****************************************
   // Port relations
   // ****************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire logic en = mode_view[15];
   sequence loop_low_s;
      (en && mode_view[6] && !mode_view[12] && core_run && !core_tx_bit)[*5];
   endsequence
   chk_upper_zero: assert property (reg_rdata[31:16] == 16'h0)
      else $error("upper read bits set");
   chk_gap_bits: assert property (!reg_rdata[14] && !reg_rdata[10] && !mode_view[14] && !mode_view[10])
      else $error("unused bit reads one");
   chk_off_quiet: assert property (!en |-> !(serial_tx_oe || request_to_send_oe || baud_clock_oe || rx_pin_owned))
      else $error("pin held while off");
   chk_tx_drive: assert property (serial_tx_oe == (en && transmit_enable && !mode_view[6]))
      else $error("tx enable wrong");
   chk_idle_halt: assert property (core_run == (en && !(mode_view[13] && device_idle)))
      else $error("run wrong in idle");
   chk_pin_usage: assert property (request_to_send_oe == (en && (mode_view[9] != mode_view[8])))
      else $error("rts pin use wrong");
   chk_rts_simplex: assert property (en && mode_view[11] && request_to_send_oe && core_tx_busy |-> !request_to_send_n)
      else $error("simplex rts idle");
   chk_loop_feed: assert property (loop_low_s |-> !core_rx_bit)
      else $error("loopback not fed");
   chk_wake_cause: assert property ($rose(wake_request) |-> $past(en) && $past(mode_view[7]) && $past(device_sleep))
      else $error("wake without cause");
   cover property ($rose(wake_request));
   cover property (loop_low_s);
   cover property (baud_clock_oe);
endmodule
bind umc_mode_ctrl umc_chk umc_chk_i (.core_clk, .reset, .reg_rdata, .transmit_enable, .device_idle, .device_sleep,
   .core_tx_bit, .core_tx_busy, .core_rx_bit, .core_run, .serial_tx_oe, .request_to_send_n, .request_to_send_oe,
   .baud_clock_oe, .rx_pin_owned, .wake_request, .mode_view);

// ===== verif/umc_remote_model.sv
/*
 Remote serial partner: idles the receive line high, sends start bits.
 Assumes the bench pulses send_start for one clock.
*/
`timescale 1ns/1ps
module umc_remote_model
(
   input wire logic core_clk,
   input wire logic send_start,
   input wire logic clear_ok,
   output logic serial_rx_pin,
   output logic clear_to_send_n
);
   logic [2:0] low_q = 3'h0;
   always @(posedge core_clk)
      if (send_start)
         low_q <= 3'h4;
      else if (low_q != 3'h0)
         low_q <= low_q - 3'h1;
   assign serial_rx_pin = (low_q == 3'h0);
   assign clear_to_send_n = ~clear_ok;
endmodule

// ===== verif/testbench.sv
/*
 Bench for the serial mode control block: register tasks and pin checks.
 Assumes the remote model drives the receive and clear-to-send pins.
*/
`timescale 1ns/1ps
module testbench;
   import umc_pkg::*;
   logic core_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, transmit_enable = 1'b1;
   logic device_idle = 1'b0, device_sleep = 1'b0, core_tx_bit = 1'b1, core_rts_request = 1'b0;
   logic core_tx_busy = 1'b0, baud_clock_in = 1'b0, send_start = 1'b0, clear_ok = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, mode_view, n;
   logic core_rx_bit, core_cts_ok, core_run, serial_tx_pin, serial_tx_oe, serial_rx_pin, request_to_send_n;
   logic request_to_send_oe, clear_to_send_n, baud_clock_out, baud_clock_oe, rx_pin_owned, cts_pin_owned;
   logic wake_request;
   int err_total = 0, total_checks = 0;
   logic [4:0] pin_exp [4] = '{5'h18, 5'h1C, 5'h1E, 5'h19};
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) baud_clock_in <= ~baud_clock_in;
   umc_mode_ctrl uut (
      .core_clk(core_clk),
      .reset(reset),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_write(reg_write),
      .reg_read(reg_read),
      .reg_rdata(reg_rdata),
      .transmit_enable(transmit_enable),
      .device_idle(device_idle),
      .device_sleep(device_sleep),
      .core_tx_bit(core_tx_bit),
      .core_rts_request(core_rts_request),
      .core_tx_busy(core_tx_busy),
      .baud_clock_in(baud_clock_in),
      .core_rx_bit(core_rx_bit),
      .core_cts_ok(core_cts_ok),
      .core_run(core_run),
      .serial_tx_pin(serial_tx_pin),
      .serial_tx_oe(serial_tx_oe),
      .serial_rx_pin(serial_rx_pin),
      .request_to_send_n(request_to_send_n),
      .request_to_send_oe(request_to_send_oe),
      .clear_to_send_n(clear_to_send_n),
      .baud_clock_out(baud_clock_out),
      .baud_clock_oe(baud_clock_oe),
      .rx_pin_owned(rx_pin_owned),
      .cts_pin_owned(cts_pin_owned),
      .wake_request(wake_request),
      .mode_view(mode_view)
   );
   umc_remote_model peer (.core_clk, .send_start, .clear_ok, .serial_rx_pin, .clear_to_send_n);
   // ****************************************
   // Tasks
   // ****************************************
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Trailing idle cycle keeps strobes from being set twice in one step
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      tick(1);
      reg_write <= 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      tick(1);
      reg_read <= 1'b0;
      tick(1);
      chk(reg_rdata, exp);
   endtask
   task automatic start_frame;
      send_start <= 1'b1;
      tick(1);
      send_start <= 1'b0;
      tick(8);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #4000;
      err_total++;
      final_report;
   end
   // ****************************************
   // Sequence
   // ****************************************
   initial
   begin
      tick(4);
      reset <= 1'b0;
      tick(1);
      rd(4'h0, 32'h0);
      wr(4'h0, 32'hFFFF_FFFF);
      rd(4'h0, 32'h0000_BBFF);
      rd(4'h8, 32'h0);
      for (int p = 0; p < 4; p++)
      begin
         wr(4'h0, 32'h8000 | (32'(p) << 8));
         chk(32'({serial_tx_oe, rx_pin_owned, request_to_send_oe, cts_pin_owned, baud_clock_oe}), 32'(pin_exp[p]));
      end
      chk(32'(baud_clock_out), 32'(baud_clock_in));
      wr(4'h0, 32'h0000_8200);
      chk(32'(core_cts_ok), 32'h0);
      clear_ok <= 1'b1;
      tick(3);
      chk(32'(core_cts_ok), 32'h1);
      wr(4'h0, 32'h0);
      tick(1);
      chk(32'({serial_tx_oe, request_to_send_oe, baud_clock_oe, rx_pin_owned, cts_pin_owned, core_run}), 32'h0);
      device_idle <= 1'b1;
      wr(4'h0, 32'h0000_A000);
      chk(32'(core_run), 32'h0);
      wr(4'h0, 32'h0000_8000);
      chk(32'(core_run), 32'h1);
      device_idle <= 1'b0;
      core_tx_busy <= 1'b1;
      wr(4'h0, 32'h0000_8900);
      chk(32'(request_to_send_n), 32'h0);
      core_tx_busy <= 1'b0;
      tick(1);
      chk(32'(request_to_send_n), 32'h1);
      core_rts_request <= 1'b1;
      wr(4'h0, 32'h0000_8100);
      chk(32'(request_to_send_n), 32'h0);
      core_tx_bit <= 1'b0;
      wr(4'h0, 32'h0000_8040);
      tick(4);
      chk(32'({core_rx_bit, serial_tx_oe}), 32'h0);
      core_tx_bit <= 1'b1;
      wr(4'h0, 32'h0000_9000);
      core_tx_bit <= 1'b0;
      n = 32'h0;
      repeat (9)
      begin
         tick(1);
         n += 32'(serial_tx_pin);
         core_tx_bit <= 1'b1;
      end
      chk(n, 32'h3);
      chk(32'(core_rx_bit), 32'h0);
      device_sleep <= 1'b1;
      wr(4'h0, 32'h0000_8000);
      start_frame;
      chk(32'(wake_request), 32'h0);
      wr(4'h0, 32'h0000_8080);
      start_frame;
      chk(32'(wake_request), 32'h1);
      rd(4'h4, 32'h0000_0007);
      wr(4'h4, 32'h0000_0004);
      chk(32'(wake_request), 32'h0);
      final_report;
   end
endmodule
